/* File: verilog/seir_top.sv */
// seir_top: axi4-lite register front end and interrupt output of the
// sticky event interrupt register block.
// assumes source levels synchronous to core_clk_in; one write, one read
// in flight at a time from the bus master.
`timescale 1ns/1ps
`default_nettype none
`include "seir_cfg.svh"

module seir_top
    import seir_pkg::*;
#(
    parameter int ADDR_W  = 8,
    parameter int AMP_W   = 8
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    // register bus
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    // level status sources
    input  wire logic              converter_lock_level_in,
    input  wire logic              adc_overflow_level_in,
    input  wire logic [1:0]        channel_x_overflow_level_in,
    input  wire logic              sub_overflow_level_in,
    input  wire logic [AMP_W-1:0]  amplifier_error_status_in,
    // interrupt toward the host
    output logic                   irq_out
);

    // -------------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie in 8..32");
    end
    if (AMP_W < 1 || AMP_W > 8) begin : g_bad_amp
        $error("AMP_W must lie in 1..8");
    end

    localparam logic [ADDR_W-1:0] OFS_EVT = ADDR_W'(`SEIR_OFS_EVT);
    localparam logic [ADDR_W-1:0] OFS_LVL = ADDR_W'(`SEIR_OFS_LVL);

    // word-aligned match; the two low address bits select no byte here
    function automatic logic seir_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
        seir_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // -------------------------------------------------------------------------
    // event capture
    // -------------------------------------------------------------------------
    seir_evt_if evt ();

    logic amp_any;
    logic ar_fire;

    assign amp_any        = |amplifier_error_status_in;
    assign evt.lock_level = converter_lock_level_in;
    assign evt.adc_level  = adc_overflow_level_in;
    assign evt.ch_level   = {sub_overflow_level_in, channel_x_overflow_level_in};
    assign evt.amp_any    = amp_any;
    // only a read of the event word clears; level word reads leave it alone
    assign evt.rd_clear   = ar_fire && seir_hit(s_axi_araddr_in, OFS_EVT);

    seir_capture u_capture (
        .clk_in (core_clk_in),
        .rst_in (sys_rst_in),
        .evt    (evt.capture)
    );

    // -------------------------------------------------------------------------
    // write channel
    // -------------------------------------------------------------------------
    logic              aw_held_reg, aw_held_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic              w_held_reg,  w_held_next;
    logic [31:0]       w_data_reg,  w_data_next;
    logic [3:0]        w_strb_reg,  w_strb_next;
    logic              awready_reg, awready_next;
    logic              wready_reg,  wready_next;
    logic              bvalid_reg,  bvalid_next;
    seir_resp_t        bresp_reg,   bresp_next;
    seir_src_vec_t     mask_reg,    mask_next;
    logic              wr_fire;

    // address and data are held separately so the master may send either first
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        mask_next    = mask_reg;
        if (s_axi_awvalid_in && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata_in;
            w_strb_next = s_axi_wstrb_in;
        end
        if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `SEIR_RESP_OKAY;
            if (seir_hit(aw_addr_reg, OFS_EVT)) begin
                // flag bits are read only; only the mask nibble takes data
                if (w_strb_reg[0]) begin
                    mask_next = w_data_reg[`SEIR_MASK_LSB +: 4];
                end
            end else if (!seir_hit(aw_addr_reg, OFS_LVL)) begin
                bresp_next = `SEIR_RESP_SLVERR;
            end
            // a write to the level word is accepted and discarded
        end
        awready_next = !aw_held_next;
        wready_next  = !w_held_next;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SEIR_RESP_OKAY;
            mask_reg    <= `SEIR_MASK_RST;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg  <= w_held_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            mask_reg    <= mask_next;
        end
    end

    // -------------------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------------------
    logic       arready_reg, arready_next;
    logic       rvalid_reg,  rvalid_next;
    seir_word_t rdata_reg,   rdata_next;
    seir_resp_t rresp_reg,   rresp_next;
    seir_word_t evt_word;
    seir_word_t lvl_word;

    assign ar_fire = s_axi_arvalid_in && arready_reg;

    always_comb begin
        evt_word = 32'h0;
        evt_word[`SEIR_FLAG_LSB +: 4] = evt.flags;
        evt_word[`SEIR_MASK_LSB +: 4] = mask_reg;
        lvl_word = 32'h0;
        lvl_word[`SEIR_LVL_LOCK]          = converter_lock_level_in;
        lvl_word[`SEIR_LVL_ADC]           = adc_overflow_level_in;
        lvl_word[`SEIR_LVL_CH_LSB +: 3]   = evt.ch_level;
        lvl_word[`SEIR_LVL_AMP_ANY]       = amp_any;
        lvl_word[`SEIR_LVL_AMP_LSB +: AMP_W] = amplifier_error_status_in;
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
        if (ar_fire) begin
            rvalid_next = 1'b1;
            rresp_next  = `SEIR_RESP_OKAY;
            if (seir_hit(s_axi_araddr_in, OFS_EVT)) begin
                rdata_next = evt_word;
            end else if (seir_hit(s_axi_araddr_in, OFS_LVL)) begin
                rdata_next = lvl_word;
            end else begin
                rdata_next = 32'h0;
                rresp_next = `SEIR_RESP_SLVERR;
            end
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= `SEIR_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // -------------------------------------------------------------------------
    // interrupt output
    // -------------------------------------------------------------------------
    logic irq_reg, irq_next;

    // built from next values so the pin moves on the same edge as the flags
    always_comb begin
        irq_next = |(evt.flags_next & mask_next);
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out  = wready_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;
    assign irq_out           = irq_reg;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_evt_read;
        s_axi_arvalid_in && s_axi_arready_out && seir_hit(s_axi_araddr_in, OFS_EVT);
    endsequence

    sequence s_lvl_read;
        s_axi_arvalid_in && s_axi_arready_out && seir_hit(s_axi_araddr_in, OFS_LVL);
    endsequence

    sequence s_mask_write;
        wr_fire && seir_hit(aw_addr_reg, OFS_EVT) && w_strb_reg[0];
    endsequence

    irq_follow_a: assert property (irq_out == |(evt.flags & mask_reg))
        else $error("interrupt does not match flags and masks");
    masked_quiet_a: assert property ((mask_reg == 4'h0) |-> !irq_out)
        else $error("interrupt active with all sources masked");
    irq_drop_a: assert property ((irq_out && mask_next == 4'h0) |=> !irq_out)
        else $error("interrupt stayed active after masks cleared");
    evt_read_a: assert property (s_evt_read |=> s_axi_rvalid_out
        && s_axi_rdata_out[`SEIR_FLAG_LSB +: 4] == $past(evt.flags))
        else $error("event read returned wrong flags");
    read_clear_a: assert property (s_evt_read |-> evt.rd_clear)
        else $error("event read did not clear");
    lvl_keep_a: assert property (s_lvl_read |-> !evt.rd_clear)
        else $error("level read cleared flags");
    mask_write_a: assert property (s_mask_write ##1 1'b1
        |-> mask_reg == $past(w_data_reg[`SEIR_MASK_LSB +: 4]))
        else $error("mask write not stored");
    poll_free_a: assert property ((!$past(evt.rd_clear) && evt.flags != 4'h0
        && $changed(mask_reg)) |-> (evt.flags & $past(evt.flags)) == $past(evt.flags))
        else $error("mask change disturbed flags");
    wr_resp_a: assert property (wr_fire |=> s_axi_bvalid_out)
        else $error("write not answered");
    r_hold_a: assert property ((s_axi_rvalid_out && !s_axi_rready_in)
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data not held");

    // -------------------------------------------------------------------------
    // level word and bus refusal checks
    // -------------------------------------------------------------------------
    // a level word write must leave the masks alone, or it could raise the pin
    sequence s_lvl_write;
        wr_fire && seir_hit(aw_addr_reg, OFS_LVL);
    endsequence

    lvl_write_a: assert property (s_lvl_write |=> $stable(mask_reg))
        else $error("level write changed the masks");
    lvl_read_a: assert property (s_lvl_read |=> s_axi_rdata_out[`SEIR_LVL_AMP_ANY]
        == $past(|amplifier_error_status_in))
        else $error("level read lost the amplifier error summary");
    bad_addr_a: assert property ((s_axi_arvalid_in && s_axi_arready_out
        && !seir_hit(s_axi_araddr_in, OFS_EVT) && !seir_hit(s_axi_araddr_in, OFS_LVL))
        |=> s_axi_rresp_out == `SEIR_RESP_SLVERR && s_axi_rdata_out == 32'h0)
        else $error("unmapped read not refused");
    // a held address or data word must not be overwritten before it fires
    aw_refuse_a: assert property (aw_held_reg |-> !s_axi_awready_out)
        else $error("write address accepted while one is held");
    w_refuse_a: assert property (w_held_reg |-> !s_axi_wready_out)
        else $error("write data accepted while one is held");
    b_hold_a: assert property ((s_axi_bvalid_out && !s_axi_bready_in)
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response not held");

endmodule // seir_top

`default_nettype wire

/* File: verilog/seir_cfg.svh */
// seir_cfg.svh: offsets, field positions, reset values and bus codes of the
// sticky event interrupt register block.
// assumes a 32-bit axi4-lite data path with one aligned word per register.
`ifndef SEIR_CFG_SVH
`define SEIR_CFG_SVH

// -----------------------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------------------
`define SEIR_OFS_EVT      8'h60
`define SEIR_OFS_LVL      8'h64

// -----------------------------------------------------------------------------
// event word layout: flags in the upper nibble, masks in the lower
// -----------------------------------------------------------------------------
`define SEIR_FLAG_LSB     4
`define SEIR_MASK_LSB     0
`define SEIR_SRC_LOCK     3
`define SEIR_SRC_ADC      2
`define SEIR_SRC_CH       1
`define SEIR_SRC_AMP      0
`define SEIR_FLAG_RST     4'h0
`define SEIR_MASK_RST     4'h0

// -----------------------------------------------------------------------------
// level status word layout
// -----------------------------------------------------------------------------
`define SEIR_LVL_LOCK     0
`define SEIR_LVL_ADC      1
`define SEIR_LVL_CH_LSB   2
`define SEIR_LVL_AMP_ANY  5
`define SEIR_LVL_AMP_LSB  8

// -----------------------------------------------------------------------------
// bus response codes
// -----------------------------------------------------------------------------
`define SEIR_RESP_OKAY    2'h0
`define SEIR_RESP_SLVERR  2'h2

`endif

/* File: verilog/seir_pkg.sv */
// seir_pkg: types shared by the sticky event interrupt register block.
// assumes seir_cfg.svh supplies all numeric constants.
package seir_pkg;

    typedef logic [3:0]  seir_src_vec_t;
    typedef logic [31:0] seir_word_t;
    typedef logic [1:0]  seir_resp_t;

endpackage

/* File: verilog/seir_evt_if.sv */
// seir_evt_if: carries source levels, the read-clear strobe and the flags
// between the bus front end and the event capture logic.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface seir_evt_if;
    logic       lock_level;
    logic       adc_level;
    logic [2:0] ch_level;
    logic       amp_any;
    logic       rd_clear;
    logic [3:0] flags;
    logic [3:0] flags_next;

    modport capture (
        input  lock_level, adc_level, ch_level, amp_any, rd_clear,
        output flags, flags_next
    );
    modport ctrl (
        output lock_level, adc_level, ch_level, amp_any, rd_clear,
        input  flags, flags_next
    );
endinterface

`default_nettype wire

/* File: verilog/seir_capture.sv */
// seir_capture: edge detection and sticky flags for the four event sources.
// assumes level inputs are synchronous to clk_in and rd_clear is one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "seir_cfg.svh"

module seir_capture
    import seir_pkg::*;
(
    input wire logic     clk_in,
    input wire logic     rst_in,
    seir_evt_if.capture  evt
);

    // -------------------------------------------------------------------------
    // edge detection
    // -------------------------------------------------------------------------
    logic          lock_prev_reg, lock_prev_next;
    logic          adc_prev_reg,  adc_prev_next;
    logic [2:0]    ch_prev_reg,   ch_prev_next;
    logic          amp_prev_reg,  amp_prev_next;
    seir_src_vec_t flags_reg,     flags_next;
    seir_src_vec_t hit;

    always_comb begin
        lock_prev_next = evt.lock_level;
        adc_prev_next  = evt.adc_level;
        ch_prev_next   = evt.ch_level;
        amp_prev_next  = evt.amp_any;
        hit = 4'h0;
        hit[`SEIR_SRC_LOCK] = evt.lock_level ^ lock_prev_reg;
        hit[`SEIR_SRC_ADC]  = evt.adc_level & ~adc_prev_reg;
        hit[`SEIR_SRC_CH]   = |(evt.ch_level & ~ch_prev_reg);
        hit[`SEIR_SRC_AMP]  = evt.amp_any & ~amp_prev_reg;
        // a new event wins over a read in the same cycle, so none is lost
        flags_next = (flags_reg & ~{4{evt.rd_clear}}) | hit;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_prev_reg <= 1'b0;
            adc_prev_reg  <= 1'b0;
            ch_prev_reg   <= 3'h0;
            amp_prev_reg  <= 1'b0;
            flags_reg     <= `SEIR_FLAG_RST;
        end else begin
            lock_prev_reg <= lock_prev_next;
            adc_prev_reg  <= adc_prev_next;
            ch_prev_reg   <= ch_prev_next;
            amp_prev_reg  <= amp_prev_next;
            flags_reg     <= flags_next;
        end
    end

    assign evt.flags      = flags_reg;
    assign evt.flags_next = flags_next;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    lock_toggle_a: assert property ($changed(evt.lock_level) |=> evt.flags[`SEIR_SRC_LOCK])
        else $error("lock change did not set its flag");
    adc_rise_a: assert property ($rose(evt.adc_level) |=> evt.flags[`SEIR_SRC_ADC])
        else $error("adc overflow did not set its flag");
    chan_rise_a: assert property (|(evt.ch_level & ~$past(evt.ch_level))
        |=> evt.flags[`SEIR_SRC_CH])
        else $error("channel overflow did not set its flag");
    amp_rise_a: assert property ($rose(evt.amp_any) |=> evt.flags[`SEIR_SRC_AMP])
        else $error("amplifier error did not set its flag");
    flag_hold_a: assert property (!evt.rd_clear |=>
        ((evt.flags & $past(evt.flags)) == $past(evt.flags)))
        else $error("flag dropped without a read");
    quiet_clear_a: assert property ((evt.rd_clear && hit == 4'h0) |=> evt.flags == 4'h0)
        else $error("read did not clear flags");

endmodule // seir_capture

`default_nettype wire

/* File: bench/seir_host_model.sv */
// seir_host_model: host side of the block, watching the interrupt pin.
// assumes irq is an active high level synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

module seir_host_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       irq_in,
    output var  logic [7:0] irq_seen_out
);
    logic irq_last_reg;

    // one count per new assertion, as a host servicing the pin would see it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_last_reg <= 1'b0;
            irq_seen_out <= 8'h00;
        end else begin
            irq_last_reg <= irq_in;
            if (irq_in && !irq_last_reg) begin
                irq_seen_out <= irq_seen_out + 8'h01;
            end
        end
    end
endmodule // seir_host_model

`default_nettype wire

/* File: bench/sticky_event_interrupt_reg_bench.sv */
// sticky_event_interrupt_reg_bench: self-checking bench of seir_top.
// assumes bready and rready may stay high; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
`include "seir_cfg.svh"

module sticky_event_interrupt_reg_bench
    import seir_pkg::*;
;
    logic       clk, rst, awvalid, wvalid, arvalid, awready, wready, bvalid;
    logic       arready, rvalid, irq, lock, adc, sub;
    logic [7:0] awaddr, araddr, amp, irq_seen;
    logic [1:0] chx;
    logic [3:0] m, f, strb;
    logic [15:0] rnd;
    seir_word_t wdata, rdata, d;
    seir_resp_t bresp, rresp, r;
    int         bad_count, checked, cycles, s;

    seir_top uut (.core_clk_in(clk), .sys_rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
        .converter_lock_level_in(lock), .adc_overflow_level_in(adc),
        .channel_x_overflow_level_in(chx), .sub_overflow_level_in(sub),
        .amplifier_error_status_in(amp), .irq_out(irq));
    seir_host_model host (.clk_in(clk), .rst_in(rst), .irq_in(irq), .irq_seen_out(irq_seen));

    // ------
    // helpers
    // ------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic seir_word_t exp_evt(input logic [3:0] fl, input logic [3:0] mk);
        return {24'h0, fl, mk};
    endfunction
    function automatic logic exp_irq(input logic [3:0] fl, input logic [3:0] mk);
        return |(fl & mk);
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_word(input seir_word_t got, input seir_word_t exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input seir_resp_t got, input seir_resp_t exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask
    task automatic chk_irq(input logic exp);
        chk_word({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input seir_word_t v, output seir_resp_t rs);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        rs = bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output seir_word_t v, output seir_resp_t rs);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
    endtask

    // channel sources pick a random contributor when raised; the amplifier source a random pattern with bit 0 set
    task automatic set_src(input int src, input logic v);
        rnd = lfsr_next(rnd);
        case (src)
            `SEIR_SRC_LOCK: lock <= v;
            `SEIR_SRC_ADC: adc <= v;
            `SEIR_SRC_CH: begin
                if (!v) begin
                    sub <= 1'b0;
                    chx <= 2'h0;
                end else if (rnd[1:0] == 2'h2) sub <= 1'b1;
                else chx[rnd[0]] <= 1'b1;
            end
            default: amp <= v ? (rnd[7:0] | 8'h01) : 8'h00;
        endcase
        @(posedge clk);
    endtask

    // ------
    // stimulus
    // ------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        {rst, awvalid, wvalid, arvalid, lock, adc, sub} = 7'h40;
        strb = 4'hf;
        {awaddr, araddr, amp, chx, wdata} = '0;
        {bad_count, checked, cycles} = '0;
        rnd = 16'h0010;
        tick(3);
        rst <= 1'b0;
        tick(2);
        axi_rd(`SEIR_OFS_EVT, d, r);
        chk_word(d, exp_evt(`SEIR_FLAG_RST, `SEIR_MASK_RST));
        chk_irq(1'b0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            axi_wr(`SEIR_OFS_EVT, 32'h1 << i, r);
            chk_resp(r, `SEIR_RESP_OKAY);
            set_src(i, 1'b1);
            tick(1);
            chk_irq(1'b1);
            axi_rd(`SEIR_OFS_EVT, d, r);
            chk_word(d, exp_evt(4'h1 << i, 4'h1 << i));
            chk_irq(1'b0);
            axi_rd(`SEIR_OFS_EVT, d, r);
            chk_word(d, exp_evt(4'h0, 4'h1 << i));
            axi_wr(`SEIR_OFS_EVT, 32'h0, r);
            set_src(i, 1'b0);
            tick(1);
            chk_irq(1'b0);
            axi_rd(`SEIR_OFS_EVT, d, r);
            chk_word(d, exp_evt((i == `SEIR_SRC_LOCK) ? 4'h8 : 4'h0, 4'h0));
        end
        chk_word({24'h0, irq_seen}, 32'h4);
        $display("test sources done");
        repeat (24) begin
            rnd = lfsr_next(rnd);
            m = rnd[3:0];
            s = int'(rnd[5:4]);
            axi_wr(`SEIR_OFS_EVT, {16'h0, rnd[15:4], m}, r);
            set_src(s, 1'b1);
            set_src(s, 1'b0);
            tick(1);
            f = 4'h1 << s;
            chk_irq(exp_irq(f, m));
            axi_rd(`SEIR_OFS_EVT, d, r);
            chk_word(d, exp_evt(f, m));
            chk_irq(1'b0);
        end
        $display("test random done");
        set_src(`SEIR_SRC_ADC, 1'b1);
        axi_rd(`SEIR_OFS_EVT, d, r);
        axi_wr(`SEIR_OFS_EVT, 32'hf, r);
        repeat (2) begin
            axi_rd(`SEIR_OFS_LVL, d, r);
            chk_word(d, 32'h1 << `SEIR_LVL_ADC);
        end
        axi_wr(`SEIR_OFS_LVL, 32'hffff, r);
        chk_resp(r, `SEIR_RESP_OKAY);
        tick(1);
        chk_irq(1'b0);
        axi_rd(8'h10, d, r);
        chk_resp(r, `SEIR_RESP_SLVERR);
        chk_word(d, 32'h0);
        axi_wr(8'h10, 32'h0, r);
        chk_resp(r, `SEIR_RESP_SLVERR);
        // lane 0 disabled: the masks must survive this write
        strb <= 4'he;
        axi_wr(`SEIR_OFS_EVT, 32'h0, r);
        strb <= 4'hf;
        chk_resp(r, `SEIR_RESP_OKAY);
        axi_rd(`SEIR_OFS_EVT, d, r);
        chk_word(d, exp_evt(4'h0, 4'hf));
        $display("test levels done");
        stop_test();
    end
endmodule // sticky_event_interrupt_reg_bench

`default_nettype wire
